// *** hdl/level_sync.sv ***
`timescale 1ns/1ns
module level_sync
  import monitor_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             clock_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] level_o
);

  // ---------------------------------------------------------------
  // three stage capture, level taken once stages two and three agree
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  // next value: per bit, accept stage three only when stable
  always_comb begin
    next_st       = st;
    next_st.s1    = async_i;
    next_st.s2    = st.s1;
    next_st.s3    = st.s2;
    next_st.level = (st.level & (st.s2 ^ st.s3)) | (st.s3 & ~(st.s2 ^ st.s3));
  end

  // register the whole state
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level_o = st.level;

endmodule : level_sync

// *** hdl/main_clock_loss_monitor.sv ***
// Strobed register access was decided locally.
`timescale 1ns/1ns
module main_clock_loss_monitor
  import monitor_pkg::*;
#(
  parameter logic [WINDOW_CNT_W-1:0] LOSS_WINDOW = WINDOW_CNT_W'(LOSS_WINDOW_DEF)
) (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic        main_clk_i,
  input  wire clk_ctrl_t   clk_ctrl_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic        bit_mode_i,
  input  wire logic [2:0]  bit_index_i,
  input  wire logic        prot_write_ok_i,
  output logic      [7:0]  rdata_o,
  output logic             reset_req_o,
  output logic             monitor_enable_o,
  output logic             monitoring_o,
  output logic             clock_loss_reset_flag_o,
  output logic             irq_o
);

  // ---------------------------------------------------------------
  // input capture
  // ---------------------------------------------------------------
  logic             main_level;
  logic [CTRL_W-1:0] ctrl_raw;
  logic [CTRL_W-1:0] ctrl_vec;
  clk_ctrl_t        ctrl;

  assign ctrl_raw = clk_ctrl_i;

  // main oscillator arrives from a foreign clock
  level_sync #(.WIDTH(1)) main_sync (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .async_i (main_clk_i),
    .level_o (main_level)
  );

  // clock generator levels live on the system clock
  level_sync #(.WIDTH(CTRL_W)) ctrl_sync (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .async_i (ctrl_raw),
    .level_o (ctrl_vec)
  );

  assign ctrl = clk_ctrl_t'(ctrl_vec);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // byte write or single bit write onto the current value
  function automatic logic [7:0] merge_write(
    input logic [7:0] cur,
    input logic [7:0] wd,
    input logic       bit_mode,
    input logic [2:0] idx
  );
    logic [7:0] res;
    res = wd;
    if (bit_mode) begin
      res      = cur;
      res[idx] = wd[0];
    end
    return res;
  endfunction : merge_write

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  monitor_state_t s;
  monitor_state_t next_s;

  logic       suspend;
  logic       main_edge;
  logic       next_hold;
  logic [7:0] view_byte;
  logic [7:0] wbyte;
  logic [EVT_W-1:0] events;

  // live view: phase, hold and pause causes
  assign view_byte = {s.phase, s.main_hold, ctrl.stop_mode | ctrl.osc_stab,
                      ctrl.internal_osc_stop, ctrl.cpu_on_internal_osc, suspend};

  always_comb begin
    next_s           = s;
    next_s.reset_req = 1'b0;
    next_s.rdata     = BYTE_ZERO;
    events           = EVT_ZERO;
    wbyte            = BYTE_ZERO;

    next_hold = s.main_hold;
    if (ctrl.main_osc_stop && ctrl.cpu_clock_select_status) begin
      next_hold = 1'b1;
    end else if (!ctrl.cpu_clock_select_status) begin
      next_hold = 1'b0;
    end
    next_s.main_hold = next_hold;

    // pause causes; halt and idle are not among them
    suspend = ctrl.stop_mode | ctrl.osc_stab | next_hold |
              ctrl.internal_osc_stop | ctrl.cpu_on_internal_osc;

    // any change of the captured main level is an edge
    main_edge        = main_level != s.main_seen;
    next_s.main_seen = main_level;

    // register writes
    if (wr_i) begin
      unique case (addr_i)
        MODE_ADDR: begin
          wbyte = merge_write(s.mode, wdata_i, bit_mode_i, bit_index_i);
          // zero never clears, upper bits stay zero
          if (prot_write_ok_i && wbyte[ENABLE_BIT]) begin
            next_s.mode[ENABLE_BIT] = 1'b1;
          end
        end
        IRQ_MASK_ADDR: begin
          wbyte           = merge_write({6'h00, s.irq_mask}, wdata_i, bit_mode_i, bit_index_i);
          next_s.irq_mask = wbyte[EVT_W-1:0];
        end
        CAUSE_ADDR: begin
          wbyte = merge_write({7'h00, s.loss_flag}, wdata_i, bit_mode_i, bit_index_i);
          if (!wbyte[FLAG_BIT]) begin
            next_s.loss_flag = 1'b0;
          end
        end
        default: begin
          wbyte = BYTE_ZERO;
        end
      endcase
    end

    // monitor phase sequence
    unique case (s.phase)
      MON_OFF: begin
        next_s.window_cnt = '0;
        if (s.mode[ENABLE_BIT]) begin
          next_s.phase = suspend ? MON_PAUSED : MON_WATCH;
        end
      end
      MON_PAUSED: begin
        next_s.window_cnt = '0;
        if (!suspend) begin
          next_s.phase                  = MON_WATCH;
          events[EVT_RESUME_BIT]        = 1'b1;
        end
      end
      MON_WATCH: begin
        if (suspend) begin
          next_s.phase      = MON_PAUSED;
          next_s.window_cnt = '0;
        end else if (main_edge) begin
          next_s.window_cnt = '0;
        end else if (s.window_cnt == LOSS_WINDOW - 1'b1) begin
          // request reset, drop enable, mark cause
          next_s.phase             = MON_OFF;
          next_s.mode              = MODE_RESET;
          next_s.loss_flag         = 1'b1;
          next_s.reset_req         = 1'b1;
          next_s.window_cnt        = '0;
          events[EVT_LOSS_BIT]     = 1'b1;
        end else begin
          next_s.window_cnt = s.window_cnt + 1'b1;
        end
      end
      default: begin
        next_s.phase = MON_OFF;
      end
    endcase

    // sticky events, a read clears, a new event wins
    if (rd_i && addr_i == IRQ_STATUS_ADDR) begin
      next_s.irq_status = events;
    end else begin
      next_s.irq_status = s.irq_status | events;
    end
    next_s.irq = |(next_s.irq_status & next_s.irq_mask);

    // read data for the following cycle
    if (rd_i) begin
      unique case (addr_i)
        MODE_ADDR:       next_s.rdata = s.mode;
        IRQ_STATUS_ADDR: next_s.rdata = {6'h00, s.irq_status};
        IRQ_MASK_ADDR:   next_s.rdata = {6'h00, s.irq_mask};
        CAUSE_ADDR:      next_s.rdata = {7'h00, s.loss_flag};
        VIEW_ADDR:       next_s.rdata = view_byte;
        default:         next_s.rdata = BYTE_ZERO;
      endcase
    end
  end

  // pin reset clears enable and stops the monitor
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s            <= '0;
      s.phase      <= MON_OFF;
      s.mode       <= MODE_RESET;
      s.irq_mask   <= MASK_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign rdata_o                 = s.rdata;
  assign reset_req_o             = s.reset_req;
  assign monitor_enable_o        = s.mode[ENABLE_BIT];
  assign monitoring_o            = s.phase[2]; // one-hot watch bit
  assign clock_loss_reset_flag_o = s.loss_flag;
  assign irq_o                   = s.irq;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  // count consecutive watching cycles, saturating
  logic [WINDOW_CNT_W-1:0] watch_age;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      watch_age <= '0;
    end else if (!monitoring_o) begin
      watch_age <= '0;
    end else if (watch_age != '1) begin
      watch_age <= watch_age + 1'b1;
    end
  end

  a_req_from_watch: assert property (
    reset_req_o |-> $past(monitoring_o) && !monitoring_o
  ) else $error("reset request without active watching");

  // enable falls only with a request
  a_enable_sticky: assert property (
    $fell(monitor_enable_o) |-> reset_req_o
  ) else $error("enable cleared without clock loss");

  // loss clears enable and sets cause
  a_loss_effects: assert property (
    reset_req_o |-> !monitor_enable_o && clock_loss_reset_flag_o && s.irq_status[0]
  ) else $error("loss did not clear enable or set cause");

  // stop or stabilisation pauses at once
  a_stop_pauses: assert property (
    (ctrl.stop_mode || ctrl.osc_stab) |=> !monitoring_o [*1] ##0 !reset_req_o
  ) else $error("watching during stop or stabilisation");

  a_hold_pauses: assert property (
    (ctrl.main_osc_stop && ctrl.cpu_clock_select_status) |=> !monitoring_o
  ) else $error("watching while main clock is stopped");

  a_osc_pauses: assert property (
    ctrl.internal_osc_stop |=> !monitoring_o
  ) else $error("watching with internal oscillator stopped");

  a_cpu_int_pauses: assert property (
    ctrl.cpu_on_internal_osc |=> !monitoring_o
  ) else $error("watching while cpu uses internal oscillator");

  // enabled and free of causes resumes next cycle
  a_auto_resume: assert property (
    (s.phase == MON_PAUSED && monitor_enable_o && !suspend) |=> monitoring_o && s.irq_status[1]
  ) else $error("monitor did not resume");

  // upper mode bits read as zero
  a_mode_fixed_zero: assert property (
    (rd_i && addr_i == MODE_ADDR) |=> rdata_o[7:1] == 7'h00
  ) else $error("mode register upper bits not zero");

  // no request before a full edgeless window
  a_window_bound: assert property (
    reset_req_o |-> watch_age >= LOSS_WINDOW
  ) else $error("loss declared before window expired");

  c_loss_seen:   cover property (reset_req_o);
  c_resume_seen: cover property ($rose(monitoring_o) && $past(s.phase == MON_PAUSED));
  c_irq_seen:    cover property ($rose(irq_o));

endmodule : main_clock_loss_monitor

// *** hdl/monitor_pkg.sv ***
package monitor_pkg;

  // ---------------------------------------------------------------
  // register map and field layout
  // ---------------------------------------------------------------
  localparam logic [31:0] MODE_ADDR        = 32'hFFFF_F870;
  localparam logic [31:0] IRQ_STATUS_ADDR  = 32'hFFFF_F874;
  localparam logic [31:0] IRQ_MASK_ADDR    = 32'hFFFF_F878;
  localparam logic [31:0] CAUSE_ADDR       = 32'hFFFF_F87C;
  localparam logic [31:0] VIEW_ADDR        = 32'hFFFF_F880;

  localparam int          ENABLE_BIT       = 0;
  localparam int          FLAG_BIT         = 0;
  localparam int          EVT_LOSS_BIT     = 0;
  localparam int          EVT_RESUME_BIT   = 1;
  localparam int          EVT_W            = 2;

  localparam logic [7:0]  MODE_RESET       = 8'h00;
  localparam logic [7:0]  BYTE_ZERO        = 8'h00;
  localparam logic [1:0]  EVT_ZERO         = 2'h0;
  localparam logic [1:0]  MASK_RESET       = 2'h0;

  // ---------------------------------------------------------------
  // timing counts
  // ---------------------------------------------------------------
  localparam int          WINDOW_CNT_W     = 8;
  localparam int          LOSS_WINDOW_DEF  = 8;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  // clock generator levels, all from the system clock domain
  typedef struct packed {
    logic stop_mode;
    logic osc_stab;
    logic main_osc_stop;
    logic cpu_clock_select_status;
    logic internal_osc_stop;
    logic cpu_on_internal_osc;
  } clk_ctrl_t;

  localparam int          CTRL_W           = 6;

  typedef enum logic [2:0] {
    MON_OFF    = 3'h1,
    MON_PAUSED = 3'h2,
    MON_WATCH  = 3'h4
  } mon_phase_t;

  typedef struct packed {
    mon_phase_t              phase;
    logic [7:0]              mode;
    logic                    loss_flag;
    logic [EVT_W-1:0]        irq_status;
    logic [EVT_W-1:0]        irq_mask;
    logic [WINDOW_CNT_W-1:0] window_cnt;
    logic                    main_seen;
    logic                    main_hold;
    logic                    reset_req;
    logic                    irq;
    logic [7:0]              rdata;
  } monitor_state_t;

endpackage : monitor_pkg

// *** verif/main_osc_model.sv ***
`timescale 1ns/1ns
// ------------------------------------------------------------
// main oscillator model, free of the sampling clock phase
// ------------------------------------------------------------
module main_osc_model (
  input  wire logic run_i,
  output logic      main_clk_o
);
  // toggles only while running, stands still when stopped; the half period
  // spans two sampling cycles and every toggle falls off the sampling edges
  initial begin
    main_clk_o = 1'b0;
    #5;
    forever begin
      if (run_i === 1'b1) begin
        main_clk_o = ~main_clk_o;
      end
      #40;
    end
  end
endmodule : main_osc_model

// *** verif/testbench.sv ***
`timescale 1ns/1ns
module testbench
  import monitor_pkg::*;
;
  logic        clock, rst_n, run, wr, rd, bitm, prot, main_clk;
  logic        req, en, mon, flag, irq;
  clk_ctrl_t   ctrl;
  logic [31:0] addr;
  logic [7:0]  wdata, rdata, v;
  logic [2:0]  bidx;
  int          error_cnt, cmp_count, req_cnt, k;
  logic [5:0]  tbl [4] = '{6'h20, 6'h10, 6'h02, 6'h01};

  initial clock = 1'b0;
  always #10 clock = ~clock;
  // count reset request pulses
  always @(posedge clock) if (req === 1'b1) req_cnt <= req_cnt + 1;

  main_osc_model u_osc (.run_i(run), .main_clk_o(main_clk));
  main_clock_loss_monitor #(.LOSS_WINDOW(8'h04)) u_dut (
    .clock_i(clock), .rst_n_i(rst_n), .main_clk_i(main_clk), .clk_ctrl_i(ctrl),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .bit_mode_i(bitm),
    .bit_index_i(bidx), .prot_write_ok_i(prot), .rdata_o(rdata), .reset_req_o(req),
    .monitor_enable_o(en), .monitoring_o(mon), .clock_loss_reset_flag_o(flag),
    .irq_o(irq));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test();
    if (error_cnt == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  task automatic cycles(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cycles
  // protected sequence flag is driven beside the write strobe
  task automatic wr_reg(input logic [31:0] a, input logic [7:0] d, input logic p,
                        input logic b);
    @(posedge clock);
    addr <= a; wdata <= d; prot <= p; bitm <= b; wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0; prot <= 1'b0; bitm <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [31:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a; rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    check({en, mon, flag, irq}, 8'h00);
    rd_reg(MODE_ADDR, v); check(v, MODE_RESET);
    rd_reg(32'hFFFF_F900, v); check(v, 8'h00);
  endtask : t_reset
  task automatic t_protect();
    wr_reg(MODE_ADDR, 8'h01, 1'b0, 1'b0); cycles(1); check(en, 1'b0);
    wr_reg(MODE_ADDR, 8'h01, 1'b1, 1'b1); cycles(2); check(en, 1'b1);
    check(mon, 1'b1);
    wr_reg(MODE_ADDR, 8'h00, 1'b1, 1'b0); cycles(1); check(en, 1'b1);
    wr_reg(MODE_ADDR, 8'hFF, 1'b1, 1'b0);
    rd_reg(MODE_ADDR, v); check(v, 8'h01);
  endtask : t_protect
  task automatic t_pause();
    rd_reg(IRQ_STATUS_ADDR, v);
    wr_reg(IRQ_MASK_ADDR, 8'h03, 1'b0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      ctrl <= clk_ctrl_t'(tbl[i]); cycles(8);
      check(mon, 1'b0);
      run <= 1'b0; cycles(20); run <= 1'b1; cycles(8);
      ctrl <= clk_ctrl_t'(6'h00); cycles(8);
      check(mon, 1'b1);
      check(8'(req_cnt), 8'h00);
    end
    check(irq, 1'b1);
    rd_reg(IRQ_STATUS_ADDR, v); check(v, 8'h02);
    cycles(1); check(irq, 1'b0);
  endtask : t_pause
  task automatic t_select();
    ctrl <= clk_ctrl_t'(6'h0C); cycles(8); check(mon, 1'b0);
    ctrl <= clk_ctrl_t'(6'h04); cycles(8); check(mon, 1'b0);
    rd_reg(VIEW_ADDR, v); check(v, 8'h51);
    ctrl <= clk_ctrl_t'(6'h00); cycles(8); check(mon, 1'b1);
  endtask : t_select
  task automatic t_loss();
    wr_reg(IRQ_MASK_ADDR, 8'h00, 1'b0, 1'b0);
    rd_reg(IRQ_STATUS_ADDR, v);
    run <= 1'b0;
    for (k = 0; k < 40 && req !== 1'b1; k++) cycles(1);
    check(req, 1'b1);
    cycles(1); check(req, 1'b0);
    check({en, flag, mon}, 8'h02);
    check(irq, 1'b0);
    wr_reg(IRQ_MASK_ADDR, 8'h01, 1'b0, 1'b0); cycles(1); check(irq, 1'b1);
    rd_reg(IRQ_STATUS_ADDR, v); check(v, 8'h01);
    cycles(1); check(irq, 1'b0);
    rd_reg(CAUSE_ADDR, v); check(v, 8'h01);
    wr_reg(CAUSE_ADDR, 8'h00, 1'b0, 1'b0); cycles(1); check(flag, 1'b0);
    check(8'(req_cnt), 8'h01);
    run <= 1'b1;
  endtask : t_loss
  task automatic t_pin();
    wr_reg(MODE_ADDR, 8'h01, 1'b1, 1'b0); cycles(2); check(mon, 1'b1);
    @(posedge clock); rst_n <= 1'b0;
    cycles(2); rst_n <= 1'b1; cycles(2);
    check({en, mon, flag}, 8'h00);
    // software enables again once the main clock has settled
    wr_reg(MODE_ADDR, 8'h01, 1'b1, 1'b0); cycles(2); check(mon, 1'b1);
  endtask : t_pin

  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    rst_n = 1'b0; run = 1'b1; wr = 1'b0; rd = 1'b0; bitm = 1'b0; prot = 1'b0;
    ctrl = clk_ctrl_t'(6'h00); addr = 32'h0000_0000; wdata = 8'h00; bidx = 3'h0;
    error_cnt = 0; cmp_count = 0; req_cnt = 0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    cycles(2);
    t_reset();
    t_protect();
    t_pause();
    t_select();
    t_loss();
    t_pin();
    end_of_test();
  end
  initial begin
    #100000;
    error_cnt++;
    end_of_test();
  end
endmodule : testbench
